// [rtl/fault_enable_key_registers.sv]
`default_nettype none
module fault_enable_key_registers #(
  parameter int WDF_HOLD_CYCLES = fault_key_pkg::WDF_LOW_CYCLES // 2 ms low pulse length
) (
  input wire logic sys_clk,
  input wire logic rst, // master power-on reset, synchronous
  // register port from the serial link front end
  input wire logic [4:0] reg_addr,
  input wire logic [15:0] reg_wdata, // D20..D5
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  output logic reg_rvalid,
  // analog fault detector levels (asynchronous)
  input wire logic pump_two_over_det,
  input wire logic pump_two_under_det,
  input wire logic sensor_rail_a_over_det,
  input wire logic sensor_rail_a_under_det,
  input wire logic sensor_rail_b_over_det,
  input wire logic sensor_rail_b_under_det,
  // rail health and watchdog fault (asynchronous)
  input wire logic mcu_rail_good,
  input wire logic general_rail_good,
  input wire logic watchdog_fault,
  // driver and regulator enables
  output logic phase_c_gate_driver,
  output logic phase_b_gate_driver,
  output logic phase_a_gate_driver,
  output logic disconnect_gate_driver,
  output logic sensor_rail_b_enable,
  output logic sensor_rail_a_enable,
  // watchdog command pulses
  output logic wd_cmd_flash,
  output logic wd_cmd_config,
  output logic wd_cmd_restart,
  output logic wd_cmd_disable,
  // active-low power-on-reset output
  output logic reset_output_n
);
  // two-flop synchronisers for all asynchronous inputs
  localparam int NSYNC = 9;
  // slot of each pin inside the synchroniser vector
  localparam int PUMP_OVER_SLOT = 0; // pump two overvoltage detector
  localparam int PUMP_UNDER_SLOT = 1; // pump two undervoltage detector
  localparam int RAIL_A_OVER_SLOT = 2; // sensor rail a overvoltage detector
  localparam int RAIL_A_UNDER_SLOT = 3; // sensor rail a undervoltage detector
  localparam int RAIL_B_OVER_SLOT = 4; // sensor rail b overvoltage detector
  localparam int RAIL_B_UNDER_SLOT = 5; // sensor rail b undervoltage detector
  localparam int MCU_GOOD_SLOT = 6; // microcontroller rail health
  localparam int GEN_GOOD_SLOT = 7; // general rail health
  localparam int WDF_SLOT = 8; // watchdog fault
  logic [NSYNC-1:0] async_in; // raw pin levels
  logic [NSYNC-1:0] sync1_reg; // first stage, read only by second
  logic [NSYNC-1:0] sync2_reg; // safe levels
  assign async_in = {watchdog_fault, general_rail_good, mcu_rail_good,
                     sensor_rail_b_under_det, sensor_rail_b_over_det,
                     sensor_rail_a_under_det, sensor_rail_a_over_det,
                     pump_two_under_det, pump_two_over_det};

  // synchroniser chain
  // only the second stage is read; the first may be metastable
  // reset leaves the health levels low, so the reset output stays low until the mcu rail level crosses
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= async_in;
      sync2_reg <= sync1_reg;
    end
  end

  // synchronised named levels
  wire logic mcu_good_s = sync2_reg[MCU_GOOD_SLOT];
  wire logic gen_good_s = sync2_reg[GEN_GOOD_SLOT];
  wire logic wdf_s = sync2_reg[WDF_SLOT];

  // true when the port address selects the given register
  function automatic logic addr_hit(input logic [4:0] addr, input logic [4:0] target);
    addr_hit = (addr == target);
  endfunction : addr_hit

  // register access decode; reads have no side effect, so the read select ignores the strobe
  wire logic wr_flags = reg_wr && addr_hit(reg_addr, fault_key_pkg::ADDR_RAIL_FAULT_FLAGS_B);
  wire logic wr_enables = reg_wr && addr_hit(reg_addr, fault_key_pkg::ADDR_DRIVER_REG_ENABLES);
  wire logic wr_keys = reg_wr && addr_hit(reg_addr, fault_key_pkg::ADDR_WATCHDOG_RESET_KEYS);
  wire logic rd_flags = addr_hit(reg_addr, fault_key_pkg::ADDR_RAIL_FAULT_FLAGS_B);
  wire logic rd_enables = addr_hit(reg_addr, fault_key_pkg::ADDR_DRIVER_REG_ENABLES);

  // ---------------- sticky fault flags ----------------
  logic [15:0] flags_reg, flags_next;
  logic [15:0] fault_set; // detector levels placed at their flag bits
  logic [15:0] flag_clear; // write-one-to-clear mask

  // place each detector at its documented bit, unused bits stay zero
  always_comb begin
    fault_set = fault_key_pkg::DATA_ZERO;
    fault_set[fault_key_pkg::POS_PUMP_TWO_OVER] = sync2_reg[PUMP_OVER_SLOT];
    fault_set[fault_key_pkg::POS_PUMP_TWO_UNDER] = sync2_reg[PUMP_UNDER_SLOT];
    fault_set[fault_key_pkg::POS_SENSOR_A_OVER] = sync2_reg[RAIL_A_OVER_SLOT];
    fault_set[fault_key_pkg::POS_SENSOR_A_UNDER] = sync2_reg[RAIL_A_UNDER_SLOT];
    fault_set[fault_key_pkg::POS_SENSOR_B_OVER] = sync2_reg[RAIL_B_OVER_SLOT];
    fault_set[fault_key_pkg::POS_SENSOR_B_UNDER] = sync2_reg[RAIL_B_UNDER_SLOT];
  end

  // only ones written clear; a zero leaves the flag alone
  assign flag_clear = wr_flags ? reg_wdata : fault_key_pkg::DATA_ZERO;
  // set wins over clear, so a live fault re-latches at once
  // a clear aimed at a fault that is still present leaves its flag set
  assign flags_next = ((flags_reg & ~flag_clear) | fault_set) & fault_key_pkg::FLAG_MASK;

  // flag storage
  always_ff @(posedge sys_clk) begin
    if (rst) flags_reg <= fault_key_pkg::DATA_ZERO;
    else flags_reg <= flags_next;
  end

  // ---------------- enable register ----------------
  // resolve a redundant pair: 11 on, 00 off, mixed keeps the old state
  function automatic logic pair_resolve(input logic hi, input logic lo, input logic prev);
    if (hi && lo) pair_resolve = 1'b1;
    else if (!hi && !lo) pair_resolve = 1'b0;
    else pair_resolve = prev;
  endfunction : pair_resolve

  logic [15:0] en_image_reg; // readback of last written pattern
  logic [5:0] en_state_reg; // resolved on/off states
  logic [5:0] en_state_next;

  // one resolver per driver or regulator
  genvar gi;
  generate
    for (gi = 0; gi < fault_key_pkg::NUM_EN; gi = gi + 1) begin : g_pair
      localparam int LO = fault_key_pkg::EN_LO_POS[gi];
      localparam int HI = LO + fault_key_pkg::PAIR_GAP;
      // slot 5 is phase c, down to slot 0 for rail a
      assign en_state_next[5 - gi] = wr_enables ?
        pair_resolve(reg_wdata[HI], reg_wdata[LO], en_state_reg[5 - gi]) :
        en_state_reg[5 - gi];
    end
  endgenerate

  // enable state and readable image
  // the image keeps the pair bits of the last written word; the unused bits read back as zero
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      en_state_reg <= fault_key_pkg::EN_STATE_RESET;
      en_image_reg <= fault_key_pkg::EN_IMAGE_RESET;
    end else begin
      en_state_reg <= en_state_next;
      if (wr_enables) en_image_reg <= reg_wdata & fault_key_pkg::EN_MASK;
    end
  end

  // drive enables straight from the state flops
  assign phase_c_gate_driver = en_state_reg[5];
  assign phase_b_gate_driver = en_state_reg[4];
  assign phase_a_gate_driver = en_state_reg[3];
  assign disconnect_gate_driver = en_state_reg[2];
  assign sensor_rail_b_enable = en_state_reg[1];
  assign sensor_rail_a_enable = en_state_reg[0];

  // ---------------- read path ----------------
  logic [15:0] rdata_next;
  // key register and unmapped addresses read as zero
  assign rdata_next = rd_flags ? flags_reg :
                      rd_enables ? en_image_reg : fault_key_pkg::DATA_ZERO;

  // registered read answer, one cycle after the strobe
  // reg_rdata keeps its word until the next read
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      reg_rdata <= fault_key_pkg::DATA_ZERO;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) reg_rdata <= rdata_next;
    end
  end

  // ---------------- key sequences ----------------
  logic wd_seq_valid, ro_seq_valid; // command byte arrived
  logic [7:0] wd_seq_byte, ro_seq_byte;

  // watchdog key field D20:D13
  key_sequencer u_wd_seq (
    .sys_clk(sys_clk),
    .rst(rst),
    .byte_valid(wr_keys),
    .byte_in(reg_wdata[fault_key_pkg::WD_FIELD_HI:fault_key_pkg::WD_FIELD_LO]),
    .key_first(fault_key_pkg::WATCHDOG_COMMAND_FIELD_FIRST),
    .key_second(fault_key_pkg::WATCHDOG_COMMAND_FIELD_SECOND),
    .cmd_valid(wd_seq_valid),
    .cmd_byte(wd_seq_byte)
  );

  // reset-output key field D12:D5
  key_sequencer u_ro_seq (
    .sys_clk(sys_clk),
    .rst(rst),
    .byte_valid(wr_keys),
    .byte_in(reg_wdata[fault_key_pkg::RO_FIELD_HI:fault_key_pkg::RO_FIELD_LO]),
    .key_first(fault_key_pkg::RO_KEY_FIRST),
    .key_second(fault_key_pkg::RO_KEY_SECOND),
    .cmd_valid(ro_seq_valid),
    .cmd_byte(ro_seq_byte)
  );

  // watchdog command decode; unknown third bytes do nothing
  wire logic dec_flash = wd_seq_valid && (wd_seq_byte == fault_key_pkg::WD_CMD_FLASH);
  wire logic dec_config = wd_seq_valid && (wd_seq_byte == fault_key_pkg::WD_CMD_CONFIG);
  wire logic dec_restart = wd_seq_valid && (wd_seq_byte == fault_key_pkg::WD_CMD_RESTART);
  wire logic dec_disable = wd_seq_valid && (wd_seq_byte == fault_key_pkg::WD_CMD_DISABLE);

  // registered one-cycle command pulses
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wd_cmd_flash <= 1'b0;
      wd_cmd_config <= 1'b0;
      wd_cmd_restart <= 1'b0;
      wd_cmd_disable <= 1'b0;
    end else begin
      wd_cmd_flash <= dec_flash;
      wd_cmd_config <= dec_config;
      wd_cmd_restart <= dec_restart;
      wd_cmd_disable <= dec_disable;
    end
  end

  // ---------------- reset-output selection ----------------
  logic incl_wdf_reg; // watchdog fault included
  logic incl_gen_reg; // general rail health included
  wire logic sel_wdf = ro_seq_valid &&
    ((ro_seq_byte == fault_key_pkg::RO_SEL_WDF) || (ro_seq_byte == fault_key_pkg::RO_SEL_BOTH));
  wire logic sel_gen = ro_seq_valid &&
    ((ro_seq_byte == fault_key_pkg::RO_SEL_GENERAL) || (ro_seq_byte == fault_key_pkg::RO_SEL_BOTH));

  // selection bits only add inputs; master reset clears them
  // a later selection adds to an earlier one, none removes any
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      incl_wdf_reg <= 1'b0;
      incl_gen_reg <= 1'b0;
    end else begin
      if (sel_wdf) incl_wdf_reg <= 1'b1;
      if (sel_gen) incl_gen_reg <= 1'b1;
    end
  end

  // watchdog fault low-time counter
  logic wdf_prev_reg; // for rising-edge detect on the synced level
  logic [19:0] hold_reg;
  wire logic wdf_rise = wdf_s && !wdf_prev_reg;
  wire logic [19:0] hold_load = 20'(WDF_HOLD_CYCLES);

  // load on a fresh included fault, then count down to zero
  // a new rising edge restarts the full low time
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wdf_prev_reg <= 1'b0;
      hold_reg <= fault_key_pkg::HOLD_ZERO;
    end else begin
      wdf_prev_reg <= wdf_s;
      if (wdf_rise && incl_wdf_reg) hold_reg <= hold_load;
      else if (hold_reg != fault_key_pkg::HOLD_ZERO) hold_reg <= hold_reg - fault_key_pkg::HOLD_ONE;
    end
  end

  // combine the selected health inputs
  // mcu rail health always counts; the others only once keyed in
  wire logic ro_low_next = !mcu_good_s ||
                           (incl_gen_reg && !gen_good_s) ||
                           (hold_reg != fault_key_pkg::HOLD_ZERO);

  // reset output held low through reset
  always_ff @(posedge sys_clk) begin
    if (rst) reset_output_n <= 1'b0;
    else reset_output_n <= !ro_low_next;
  end
endmodule : fault_enable_key_registers
`default_nettype wire

// [rtl/fault_key_pkg.sv]
`default_nettype none
package fault_key_pkg;
  // register addresses on the serial register port (5-bit message id)
  localparam logic [4:0] ADDR_RAIL_FAULT_FLAGS_B = 5'h05;
  localparam logic [4:0] ADDR_DRIVER_REG_ENABLES = 5'h06;
  localparam logic [4:0] ADDR_WATCHDOG_RESET_KEYS = 5'h07;

  // data word D20..D5 maps onto bits 15..0
  localparam int DATA_W = 16;
  localparam logic [15:0] DATA_ZERO = 16'h0000;

  // flag bit positions inside rail_fault_flags_b
  localparam int POS_PUMP_TWO_OVER = 15; // D20
  localparam int POS_PUMP_TWO_UNDER = 14; // D19
  localparam int POS_SENSOR_A_OVER = 11; // D16
  localparam int POS_SENSOR_A_UNDER = 10; // D15
  localparam int POS_SENSOR_B_OVER = 9; // D14
  localparam int POS_SENSOR_B_UNDER = 8; // D13
  localparam logic [15:0] FLAG_MASK = 16'hcf00;

  // redundant enable pairs: high bit sits four above the low bit
  localparam int NUM_EN = 6;
  localparam int PAIR_GAP = 4;
  // low bit of each pair: phase c, phase b, phase a, disconnect, rail b, rail a
  localparam int EN_LO_POS [NUM_EN] = '{11, 10, 9, 8, 3, 2};
  localparam logic [5:0] EN_STATE_RESET = 6'h03; // rails on, drivers off
  localparam logic [15:0] EN_IMAGE_RESET = 16'h00cc;
  localparam logic [15:0] EN_MASK = 16'hffcc;

  // key register fields
  localparam int WD_FIELD_HI = 15; // D20
  localparam int WD_FIELD_LO = 8; // D13
  localparam int RO_FIELD_HI = 7; // D12
  localparam int RO_FIELD_LO = 0; // D5

  // watchdog key sequence and commands
  localparam logic [7:0] WATCHDOG_COMMAND_FIELD_FIRST = 8'hd3;
  localparam logic [7:0] WATCHDOG_COMMAND_FIELD_SECOND = 8'h33;
  localparam logic [7:0] WD_CMD_FLASH = 8'hcc;
  localparam logic [7:0] WD_CMD_CONFIG = 8'hcd;
  localparam logic [7:0] WD_CMD_RESTART = 8'hce;
  localparam logic [7:0] WD_CMD_DISABLE = 8'hcf;

  // reset-output key sequence and selections
  localparam logic [7:0] RO_KEY_FIRST = 8'hd4;
  localparam logic [7:0] RO_KEY_SECOND = 8'h2b;
  localparam logic [7:0] RO_SEL_WDF = 8'ha5;
  localparam logic [7:0] RO_SEL_GENERAL = 8'ha6;
  localparam logic [7:0] RO_SEL_BOTH = 8'ha7;

  // watchdog fault low time on the reset output
  localparam int WDF_LOW_TIME_US = 2000;
  localparam int CLK_MHZ = 250;
  localparam int WDF_LOW_CYCLES = WDF_LOW_TIME_US * CLK_MHZ;
  localparam int HOLD_W = 20;
  localparam logic [19:0] HOLD_ZERO = 20'h00000;
  localparam logic [19:0] HOLD_ONE = 20'h00001;

  // key sequencer states
  typedef enum logic [1:0] {
    SEQ_FIRST,
    SEQ_SECOND,
    SEQ_COMMAND
  } seq_state_e;
endpackage : fault_key_pkg
`default_nettype wire

// [rtl/key_sequencer.sv]
`default_nettype none
// three-step keyed command tracker: key, key, command byte
module key_sequencer (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic byte_valid, // one byte offered this cycle
  input wire logic [7:0] byte_in,
  input wire logic [7:0] key_first,
  input wire logic [7:0] key_second,
  output logic cmd_valid, // one-cycle pulse after a full sequence
  output logic [7:0] cmd_byte
);
  fault_key_pkg::seq_state_e state_reg, state_next;
  logic cmd_valid_next;
  logic [7:0] cmd_byte_next;

  // advance on matching keys, fall back to the first key otherwise
  always_comb begin
    state_next = state_reg;
    cmd_valid_next = 1'b0;
    cmd_byte_next = cmd_byte;
    if (byte_valid) begin
      case (state_reg)
        fault_key_pkg::SEQ_FIRST: begin
          if (byte_in == key_first) state_next = fault_key_pkg::SEQ_SECOND;
        end
        fault_key_pkg::SEQ_SECOND: begin
          // a wrong second key forces a restart from the first key
          if (byte_in == key_second) state_next = fault_key_pkg::SEQ_COMMAND;
          else state_next = fault_key_pkg::SEQ_FIRST;
        end
        fault_key_pkg::SEQ_COMMAND: begin
          // command byte is handed up; the caller judges it
          cmd_valid_next = 1'b1;
          cmd_byte_next = byte_in;
          state_next = fault_key_pkg::SEQ_FIRST;
        end
        default: begin
          state_next = fault_key_pkg::SEQ_FIRST;
        end
      endcase
    end
  end

  // state and registered command outputs
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_reg <= fault_key_pkg::SEQ_FIRST;
      cmd_valid <= 1'b0;
      cmd_byte <= 8'h00;
    end else begin
      state_reg <= state_next;
      cmd_valid <= cmd_valid_next;
      cmd_byte <= cmd_byte_next;
    end
  end
endmodule : key_sequencer
`default_nettype wire

// [verif/fault_key_props.sv]
`default_nettype none
// port-level checks on the fault, enable and key register block
module fault_key_props #(
  parameter int WDF_HOLD_CYCLES = 20 // reset-output low time on a watchdog fault
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [4:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic pump_two_over_det,
  input wire logic mcu_rail_good,
  input wire logic phase_c_gate_driver,
  input wire logic phase_b_gate_driver,
  input wire logic sensor_rail_a_enable,
  input wire logic wd_cmd_flash,
  input wire logic reset_output_n
);
  timeunit 1ns;
  timeprecision 1ps;
  // one clock domain, reset aborts every attempt
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // write strobe aimed at the enable register
  wire logic en_wr = reg_wr && reg_addr == 5'h06;
  // read strobe aimed at the flag register
  wire logic flag_rd = reg_rd && reg_addr == 5'h05;

  read_answer_a: assert property (reg_rd |=> reg_rvalid) else $error("read not answered");
  no_spurious_a: assert property (!reg_rd |=> !reg_rvalid) else $error("answer without read");
  key_read_zero_a: assert property (reg_rd && reg_addr == 5'h07 |=> reg_rdata == 16'h0000)
    else $error("key register read back data");
  unused_zero_a: assert property (flag_rd |=> (reg_rdata & 16'h30ff) == 16'h0000)
    else $error("unused flag bit set");
  flag_latch_a: assert property (pump_two_over_det [*4] ##0 flag_rd |=> reg_rdata[15])
    else $error("pump over flag not latched");
  drive_on_a: assert property (en_wr && reg_wdata[15] && reg_wdata[11] |=> phase_c_gate_driver)
    else $error("phase c not enabled");
  drive_off_a: assert property (en_wr && !reg_wdata[15] && !reg_wdata[11] |=> !phase_c_gate_driver)
    else $error("phase c not disabled");
  mixed_hold_a: assert property (en_wr && reg_wdata[14] != reg_wdata[10] |=> $stable(phase_b_gate_driver))
    else $error("phase b moved on mixed code");
  rail_on_a: assert property (en_wr && reg_wdata[6] && reg_wdata[2] |=> sensor_rail_a_enable)
    else $error("rail a not enabled");
  cmd_pulse_a: assert property (wd_cmd_flash |=> !wd_cmd_flash) else $error("flash pulse too long");
  mcu_low_a: assert property (!mcu_rail_good [*4] |=> !reset_output_n)
    else $error("reset output high with mcu rail bad");

  // main scenarios reached
  cover property (wd_cmd_flash);
  cover property ($fell(reset_output_n));
  cover property ($rose(phase_c_gate_driver));
endmodule : fault_key_props
`default_nettype wire

// [verif/host_model.sv]
`default_nettype none
// host on the register port: single-cycle strobes launched on falling edges
module host_model (
  input wire logic sys_clk,
  output logic [4:0] reg_addr,
  output logic [15:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic reg_rvalid
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle bus at time zero
  initial begin
    reg_addr = 5'h00;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // one write; the released bus shows the inverse, never the stale word
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(negedge sys_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge sys_clk);
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask : wr
  // one read; a missing answer returns unknown data
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(negedge sys_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge sys_clk);
    reg_rd = 1'b0;
    reg_addr = ~a;
    d = reg_rvalid ? reg_rdata : 16'hxxxx;
  endtask : rd
  // three words into one key field; wd picks the watchdog field
  task automatic keys(input logic wd, input logic [7:0] b0, b1, b2);
    logic [7:0] b [3];
    b = '{b0, b1, b2};
    foreach (b[i]) wr(5'h07, wd ? {b[i], 8'h00} : {8'h00, b[i]});
  endtask : keys
endmodule : host_model
`default_nettype wire

// [verif/tb_top.sv]
`default_nettype none
// self-checking bench for the fault, enable and key registers
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HOLD = 20; // shortened reset-output low time
  logic sys_clk, rst, reg_wr, reg_rd, reg_rvalid, reset_output_n;
  logic mcu_rail_good, general_rail_good, watchdog_fault;
  logic [4:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, rd_val, w;
  logic [5:0] det; // pump over/under, rail a over/under, rail b over/under
  logic [5:0] drv; // phase c, b, a, disconnect, rail b, rail a
  logic [3:0] cmd; // flash, config, restart, disable
  logic [5:0] m_st; // reference enable states
  int err_total, tests_run, seed, cnt, m_flags, m_img;
  int fpos [$] = '{15, 14, 11, 10, 9, 8}; // flag positions, pump over first
  logic [7:0] wdc [4] = '{8'hcc, 8'hcd, 8'hce, 8'hcf};

  fault_enable_key_registers #(.WDF_HOLD_CYCLES(HOLD)) i_dut (
    .sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .pump_two_over_det(det[5]), .pump_two_under_det(det[4]), .sensor_rail_a_over_det(det[3]),
    .sensor_rail_a_under_det(det[2]), .sensor_rail_b_over_det(det[1]), .sensor_rail_b_under_det(det[0]),
    .mcu_rail_good(mcu_rail_good), .general_rail_good(general_rail_good), .watchdog_fault(watchdog_fault),
    .phase_c_gate_driver(drv[5]), .phase_b_gate_driver(drv[4]), .phase_a_gate_driver(drv[3]),
    .disconnect_gate_driver(drv[2]), .sensor_rail_b_enable(drv[1]), .sensor_rail_a_enable(drv[0]),
    .wd_cmd_flash(cmd[3]), .wd_cmd_config(cmd[2]), .wd_cmd_restart(cmd[1]), .wd_cmd_disable(cmd[0]),
    .reset_output_n(reset_output_n));
  host_model i_host (.sys_clk(sys_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

  // compare one value, count and report
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : chk
  // read a register and compare
  task automatic rdchk(input logic [4:0] a, input logic [15:0] exp);
    i_host.rd(a, rd_val);
    chk(rd_val, exp);
  endtask : rdchk
  // wait n falling edges
  task automatic idle(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : idle
  // reset for three cycles, then check the enable, reset-output and register defaults
  task automatic do_reset();
    @(negedge sys_clk);
    rst = 1'b1;
    idle(3);
    rst = 1'b0;
    m_flags = 0;
    m_img = 16'h00cc;
    m_st = 6'h03;
    idle(6);
    chk(drv, m_st);
    chk(reset_output_n, 1'b1);
    rdchk(5'h05, 16'h0000);
    rdchk(5'h06, m_img[15:0]);
    rdchk(5'h07, 16'h0000);
    rdchk(5'h1f, 16'h0000);
  endtask : do_reset
  // verdict
  task automatic tally_and_finish();
    $display("comparisons %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : tally_and_finish

  // 250 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  // hang guard, well beyond the expected run
  initial begin
    #200000;
    err_total++;
    tally_and_finish();
  end
  // main sequence
  initial begin
    rst = 1'b1;
    det = 6'h00;
    mcu_rail_good = 1'b1;
    general_rail_good = 1'b0;
    watchdog_fault = 1'b0;
    err_total = 0;
    tests_run = 0;
    seed = 44;
    do_reset();
    // each detector pulses once; flags stay set
    foreach (fpos[i]) begin
      det[5 - i] = 1'b1;
      idle(5);
      det[5 - i] = 1'b0;
      idle(4);
      m_flags |= 1 << fpos[i];
      rdchk(5'h05, m_flags[15:0]);
    end
    i_host.wr(5'h05, 16'h0000);
    rdchk(5'h05, m_flags[15:0]);
    w = 16'($random(seed));
    i_host.wr(5'h05, w);
    m_flags &= ~w;
    rdchk(5'h05, m_flags[15:0]);
    // a fault still present survives the clear
    det[5] = 1'b1;
    idle(5);
    i_host.wr(5'h05, 16'hffff);
    rdchk(5'h05, 16'h8000);
    det[5] = 1'b0;
    idle(4);
    i_host.wr(5'h05, 16'hffff);
    rdchk(5'h05, 16'h0000);
    // random enable words, mixed pairs hold
    repeat (24) begin
      w = 16'($random(seed));
      i_host.wr(5'h06, w);
      for (int i = 0; i < 6; i++) begin
        cnt = fault_key_pkg::EN_LO_POS[i];
        if (w[cnt] == w[cnt + 4]) m_st[5 - i] = w[cnt];
      end
      m_img = w & fault_key_pkg::EN_MASK;
      chk(drv, m_st);
      rdchk(5'h06, m_img[15:0]);
    end
    // wrong watchdog key restarts the sequence
    i_host.keys(1'b1, 8'hd3, 8'h5a, 8'h33);
    i_host.wr(5'h07, 16'hcc00);
    idle(1);
    chk(cmd, 4'h0);
    foreach (wdc[i]) begin
      i_host.keys(1'b1, 8'hd3, 8'h33, wdc[i]);
      chk(cmd, 4'h0);
      idle(1);
      chk(cmd, 4'h8 >> i);
    end
    // reset output selection
    i_host.keys(1'b0, 8'hd4, 8'h77, 8'ha6);
    idle(4);
    chk(reset_output_n, 1'b1);
    i_host.keys(1'b0, 8'hd4, 8'h2b, 8'ha6);
    idle(4);
    chk(reset_output_n, 1'b0);
    general_rail_good = 1'b1;
    idle(5);
    chk(reset_output_n, 1'b1);
    i_host.keys(1'b0, 8'hd4, 8'h2b, 8'ha5);
    idle(2);
    watchdog_fault = 1'b1;
    cnt = 0;
    while (reset_output_n !== 1'b0 && cnt < 8) begin
      idle(1);
      cnt++;
    end
    cnt = 0;
    while (reset_output_n === 1'b0 && cnt < 100) begin
      idle(1);
      cnt++;
    end
    chk(cnt >= HOLD && cnt <= HOLD + 1, 1'b1);
    watchdog_fault = 1'b0;
    mcu_rail_good = 1'b0;
    idle(5);
    chk(reset_output_n, 1'b0);
    mcu_rail_good = 1'b1;
    general_rail_good = 1'b0;
    do_reset();
    tally_and_finish();
  end
endmodule : tb_top

bind fault_enable_key_registers fault_key_props #(.WDF_HOLD_CYCLES(WDF_HOLD_CYCLES)) i_props (
  .sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .pump_two_over_det(pump_two_over_det),
  .mcu_rail_good(mcu_rail_good), .phase_c_gate_driver(phase_c_gate_driver),
  .phase_b_gate_driver(phase_b_gate_driver), .sensor_rail_a_enable(sensor_rail_a_enable),
  .wd_cmd_flash(wd_cmd_flash), .reset_output_n(reset_output_n));
`default_nettype wire
